// [rtl/dbg_access_pkg.sv]
`default_nettype none
package dbg_access_pkg;
	// Default widths and depths
	localparam int ADDR_W_DEF = 24;
	localparam int DATA_W = 32;
	localparam int LANE_N = 4;
	localparam int FIFO_DEPTH_DEF = 16;

	// Host commands
	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_WRITE = 2'h1,
		OP_FILL = 2'h2,
		OP_DUMP = 2'h3
	} op_type;

	// Access sizes, log2 of the byte count
	typedef enum logic [1:0] {
		SZ8 = 2'h0,
		SZ16 = 2'h1,
		SZ32 = 2'h2
	} size_type;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_BUS = 3'h2,
		ST_PUSH = 3'h4
	} state_type;

	// Reset values and lane numbers
	localparam size_type SZ_RST = SZ8;
	localparam logic [1:0] LANE_LOW = 2'h0;
	localparam logic [1:0] LANE_WORD_HI = 2'h2;
	localparam logic [1:0] LANE_LAST = 2'h3;
endpackage
`default_nettype wire

// [rtl/byte_lane_map.sv]
`default_nettype none
module byte_lane_map (
	input wire dbg_access_pkg::size_type size,
	input wire logic [1:0] lane,
	input wire logic [dbg_access_pkg::DATA_W-1:0] wr_data,
	input wire logic [dbg_access_pkg::DATA_W-1:0] rd_word,
	output logic [dbg_access_pkg::LANE_N-1:0] be,
	output logic [dbg_access_pkg::DATA_W-1:0] wr_lanes,
	output logic [dbg_access_pkg::DATA_W-1:0] rd_data
);
	import dbg_access_pkg::*;

	logic [1:0] sh_bytes;
	logic [4:0] sh_bits;
	logic [DATA_W-1:0] mask;
	logic [DATA_W-1:0] lane_mask;

	// Lane 00 is the top byte; the high data byte sits on the addressed lane
	always_comb begin
		unique case (size)
			SZ32: begin
				sh_bytes = LANE_LOW;
				mask = 32'hffffffff;
			end
			SZ16: begin
				sh_bytes = 2'(LANE_WORD_HI - lane);
				mask = 32'h0000ffff;
			end
			default: begin
				sh_bytes = 2'(LANE_LAST - lane);
				mask = 32'h000000ff;
			end
		endcase
	end

	// Place write data, extract read data
	assign sh_bits = {sh_bytes, 3'h0};
	assign wr_lanes = (wr_data & mask) << sh_bits; // R6
	assign rd_data = (rd_word >> sh_bits) & mask; // R6
	assign lane_mask = mask << sh_bits;

	// One strobe per lane
	for (genvar i = 0; i < LANE_N; i++) begin : g_lane
		assign be[i] = |lane_mask[8*i +: 8]; // R6
	end
endmodule
`default_nettype wire

// [rtl/sync_fifo.sv]
`default_nettype none
module sync_fifo #(
	parameter int WIDTH = dbg_access_pkg::DATA_W,
	parameter int DEPTH = dbg_access_pkg::FIFO_DEPTH_DEF
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import dbg_access_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW-1:0] wr_ptr_ff, rd_ptr_ff;
	logic [CW-1:0] cnt_ff;
	logic out_valid_ff;
	logic [WIDTH-1:0] out_data_ff;
	logic push, pop;

	// Full when the array holds DEPTH words
	assign in_ready = cnt_ff != CW'(DEPTH);
	assign push = in_valid && in_ready;
	assign pop = (cnt_ff != '0) && (!out_valid_ff || out_ready);
	assign out_valid = out_valid_ff;
	assign out_data = out_data_ff;

	// Storage write
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= PW'((wr_ptr_ff + 1'b1) % DEPTH);
			end
			if (pop) begin
				rd_ptr_ff <= PW'((rd_ptr_ff + 1'b1) % DEPTH);
			end
			cnt_ff <= CW'(cnt_ff + push - pop);
		end
	end

	// Registered output stage
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			out_valid_ff <= 1'b0;
			out_data_ff <= '0;
		end else if (pop) begin
			out_valid_ff <= 1'b1;
			out_data_ff <= mem_ff[rd_ptr_ff];
		end else if (out_ready) begin
			out_valid_ff <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [rtl/debug_mem_aligner.sv]
// Behaviour
// R1: Fill/dump address is previous access address plus previous access size.
// R2: Misaligned 32-bit access clears address bits 1:0; next follows on.
// R3: Realigned 16-bit access keeps its original address as increment base.
// R4: 16-bit access at offset 11 is moved onto lanes 10 and 11.
// R5: 16-bit access at offset 01 stays on lanes 01 and 10.
// R6: Lanes: 32-bit fixed, 16-bit high byte addressed, 8-bit on its lane.
// R7: After a realigned offset-11 word, next access uses original base.
// R8: Host issues a single read or write before any fill or dump; the testbench issues a dump first after its second reset.
`default_nettype none
module debug_mem_aligner #(
	parameter int ADDR_W = dbg_access_pkg::ADDR_W_DEF,
	parameter int FIFO_DEPTH = dbg_access_pkg::FIFO_DEPTH_DEF
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire dbg_access_pkg::op_type cmd_op,
	input wire dbg_access_pkg::size_type cmd_size,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [dbg_access_pkg::DATA_W-1:0] cmd_wdata,
	output logic mem_req,
	output logic mem_we,
	output logic [ADDR_W-1:0] mem_addr,
	output logic [dbg_access_pkg::LANE_N-1:0] mem_be,
	output logic [dbg_access_pkg::DATA_W-1:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [dbg_access_pkg::DATA_W-1:0] mem_rdata,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [dbg_access_pkg::DATA_W-1:0] rd_data,
	output logic done,
	output logic realigned
);
	import dbg_access_pkg::*;

	state_type state_ff;
	logic cmd_ready_ff, mem_req_ff, mem_we_ff, done_ff, realign_ff;
	logic cur_rd_ff, push_valid_ff;
	logic [ADDR_W-1:0] base_ff, mem_addr_ff;
	logic [LANE_N-1:0] mem_be_ff, lane_be;
	logic [DATA_W-1:0] mem_wdata_ff, push_data_ff, lane_wdata, rd_just;
	size_type prev_sz_ff, cur_sz_ff, map_sz;
	logic [1:0] lane_ff, map_lane;
	logic [ADDR_W-1:0] step, acc_addr, eff_addr;
	logic take, seq_cmd, is_read, do_realign, fifo_in_ready;

	// Outputs straight from flops
	assign cmd_ready = cmd_ready_ff;
	assign mem_req = mem_req_ff;
	assign mem_we = mem_we_ff;
	assign mem_addr = mem_addr_ff;
	assign mem_be = mem_be_ff;
	assign mem_wdata = mem_wdata_ff;
	assign done = done_ff;
	assign realigned = realign_ff;

	// Command decode
	assign take = (state_ff == ST_IDLE) && cmd_valid && cmd_ready_ff;
	assign seq_cmd = (cmd_op == OP_FILL) || (cmd_op == OP_DUMP);
	assign is_read = (cmd_op == OP_READ) || (cmd_op == OP_DUMP);

	// Follow-on address from the previous access and its size
	assign step = {{(ADDR_W-1){1'b0}}, 1'b1} << prev_sz_ff; // R1
	assign acc_addr = seq_cmd ? base_ff + step : cmd_addr; // R1 R8

	// Realignment of the access itself
	always_comb begin
		eff_addr = acc_addr;
		do_realign = 1'b0;
		if (cmd_size == SZ32 && acc_addr[1:0] != LANE_LOW) begin
			eff_addr[1:0] = LANE_LOW; // R2
			do_realign = 1'b1;
		end else if (cmd_size == SZ16 && acc_addr[1:0] == LANE_LAST) begin
			eff_addr[1:0] = LANE_WORD_HI; // R4
			do_realign = 1'b1;
		end
		// Offset 01 word passes through onto lanes 01 and 10 R5
	end

	// Lane mapper sees the new command while idle, else the open access
	assign map_sz = (state_ff == ST_IDLE) ? cmd_size : cur_sz_ff;
	assign map_lane = (state_ff == ST_IDLE) ? eff_addr[1:0] : lane_ff;

	byte_lane_map u_lanes (
		.size(map_sz),
		.lane(map_lane),
		.wr_data(cmd_wdata),
		.rd_word(mem_rdata),
		.be(lane_be),
		.wr_lanes(lane_wdata),
		.rd_data(rd_just)
	);

	// Sequencer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (take) begin
						state_ff <= ST_BUS;
					end
				end
				ST_BUS: begin
					if (mem_ack) begin
						state_ff <= cur_rd_ff ? ST_PUSH : ST_IDLE;
					end
				end
				ST_PUSH: begin
					if (fifo_in_ready) begin
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Increment base: aligned for longwords, original for words
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			base_ff <= '0;
			prev_sz_ff <= SZ_RST;
		end else if (take) begin
			base_ff <= (cmd_size == SZ32) ? eff_addr : acc_addr; // R2 R3 R7
			prev_sz_ff <= cmd_size; // R1
		end
	end

	// Access attributes held for the bus phase
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cur_sz_ff <= SZ_RST;
			lane_ff <= LANE_LOW;
			cur_rd_ff <= 1'b0;
			realign_ff <= 1'b0;
		end else if (take) begin
			cur_sz_ff <= cmd_size;
			lane_ff <= eff_addr[1:0];
			cur_rd_ff <= is_read;
			realign_ff <= do_realign;
		end
	end

	// Memory bus request
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mem_req_ff <= 1'b0;
			mem_we_ff <= 1'b0;
			mem_addr_ff <= '0;
			mem_be_ff <= '0;
			mem_wdata_ff <= '0;
		end else if (take) begin
			mem_req_ff <= 1'b1;
			mem_we_ff <= !is_read;
			mem_addr_ff <= {eff_addr[ADDR_W-1:2], LANE_LOW};
			mem_be_ff <= lane_be; // R6
			mem_wdata_ff <= lane_wdata; // R6
		end else if (mem_req_ff && mem_ack) begin
			mem_req_ff <= 1'b0;
		end
	end

	// Read data waits here while the FIFO is full
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			push_valid_ff <= 1'b0;
			push_data_ff <= '0;
		end else if (state_ff == ST_BUS && mem_ack && cur_rd_ff) begin
			push_valid_ff <= 1'b1;
			push_data_ff <= rd_just; // R6
		end else if (fifo_in_ready) begin
			push_valid_ff <= 1'b0;
		end
	end

	// Command handshake and completion pulse
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cmd_ready_ff <= 1'b1;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (take) begin
				cmd_ready_ff <= 1'b0;
			end else if ((state_ff == ST_BUS && mem_ack && !cur_rd_ff) ||
				(state_ff == ST_PUSH && fifo_in_ready)) begin
				cmd_ready_ff <= 1'b1;
				done_ff <= 1'b1;
			end
		end
	end

	sync_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(push_valid_ff),
		.in_ready(fifo_in_ready),
		.in_data(push_data_ff),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// Checking helpers
	logic [ADDR_W-1:0] chk_next;
	logic [ADDR_W-3:0] chk_word, base_word;
	logic mem_start, mem_req_d_ff;

	always_comb begin
		unique case (prev_sz_ff)
			SZ8: chk_next = base_ff + 1'b1;
			SZ16: chk_next = base_ff + 2'h2;
			default: chk_next = base_ff + 3'h4;
		endcase
	end
	assign chk_word = chk_next[ADDR_W-1:2];
	assign base_word = base_ff[ADDR_W-1:2];
	assign mem_start = mem_req_ff && !mem_req_d_ff;

	// Request delayed a cycle to find the first cycle of an access
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mem_req_d_ff <= 1'b0;
		end else begin
			mem_req_d_ff <= mem_req_ff;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_fill_incr: assert property ( // R1
		take && seq_cmd |=> mem_addr_ff[ADDR_W-1:2] == $past(chk_word))
		else $error("follow-on address not previous plus size");

	a_long_align: assert property ( // R2
		mem_start && cur_sz_ff == SZ32 |->
		base_ff[1:0] == 2'h0 && mem_be_ff == 4'hf &&
		mem_addr_ff == base_ff)
		else $error("longword access not forced aligned");

	a_word_base: assert property ( // R3
		take && cmd_size == SZ16 |=> base_ff == $past(acc_addr))
		else $error("word base not the original address");

	a_word_realign: assert property ( // R4
		mem_start && cur_sz_ff == SZ16 && base_ff[1:0] == 2'h3 |->
		mem_be_ff == 4'h3 && realign_ff && lane_ff == LANE_WORD_HI)
		else $error("offset 11 word not on lanes 10 and 11");

	a_word_odd: assert property ( // R5
		mem_start && cur_sz_ff == SZ16 && base_ff[1:0] == 2'h1 |->
		mem_be_ff == 4'h6 && !realign_ff)
		else $error("offset 01 word not on lanes 01 and 10");

	a_byte_lane: assert property ( // R6
		take && cmd_size == SZ8 && cmd_op == OP_WRITE |=>
		mem_be_ff == (4'h8 >> lane_ff) &&
		mem_wdata_ff == ($past(cmd_wdata) & 32'h000000ff) <<
		{LANE_LAST - lane_ff, 3'h0})
		else $error("byte not on its addressed lane");

	a_word_next: assert property ( // R7
		take && seq_cmd && realign_ff && cur_sz_ff == SZ16 |=>
		mem_addr_ff[ADDR_W-1:2] == (ADDR_W-2)'($past(base_word) + 1'b1))
		else $error("follow-on after realigned word misplaced");

	// Lane strobes, base clearing, realign flag, request hold and byte read justification
	a_word_lanes: assert property ( // R6
		mem_start && cur_sz_ff == SZ16 |->
		mem_be_ff == (4'hc >> lane_ff))
		else $error("word strobes not on the addressed lane pair");

	a_long_base: assert property ( // R2
		take && cmd_size == SZ32 |=> base_ff[1:0] == LANE_LOW &&
		mem_be_ff == 4'hf)
		else $error("longword base not cleared to the field start");

	a_long_flag: assert property ( // R2
		take && cmd_size == SZ32 && acc_addr[1:0] != 2'h0 |=>
		realign_ff)
		else $error("misaligned longword not flagged realigned");

	a_req_held: assert property ( // R6
		mem_req_ff && !mem_ack |=>
		mem_req_ff && $stable(mem_addr_ff) && $stable(mem_be_ff))
		else $error("memory request dropped or changed before ack");

	a_read_just: assert property ( // R6
		state_ff == ST_BUS && mem_ack && cur_rd_ff &&
		cur_sz_ff == SZ8 |=> push_data_ff[DATA_W-1:8] == '0)
		else $error("byte read not right justified");

	c_word_realign: cover property (take && seq_cmd && do_realign &&
		cmd_size == SZ16);
	c_long_dump: cover property (take && cmd_op == OP_DUMP &&
		cmd_size == SZ32);
	c_fifo_stall: cover property (push_valid_ff && !fifo_in_ready);
	c_word_odd: cover property (mem_start && cur_sz_ff == SZ16 &&
		lane_ff == 2'h1);
endmodule
`default_nettype wire

// [testbench/mem_partner.sv]
`default_nettype none
module mem_partner (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic mem_req,
	input wire logic [23:0] mem_addr,
	input wire logic [1:0] lat,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_ff;
	logic [7:0] b;
	logic [31:0] pat;
	// One ack pulse per request after a chosen wait
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mem_ack <= 1'b0;
			wait_ff <= 2'h0;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			wait_ff <= lat;
		end else if (mem_req) begin
			if (wait_ff == 2'h0)
				mem_ack <= 1'b1;
			else
				wait_ff <= wait_ff - 2'h1;
		end
	end
	// Lane bytes follow the address; inverted when not answering
	assign b = mem_addr[7:0];
	assign pat = {b, b + 8'h1, b + 8'h2, b + 8'h3};
	assign mem_rdata = mem_ack ? pat : ~pat;
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`default_nettype none
module testbench
	import dbg_access_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst, cmd_valid, cmd_ready, mem_req, mem_we, mem_ack;
	logic rd_valid, rd_ready, done, realigned, hold;
	op_type cmd_op;
	size_type cmd_size, psz;
	logic [23:0] cmd_addr, mem_addr, base;
	logic [31:0] cmd_wdata, mem_wdata, mem_rdata, rd_data;
	logic [3:0] mem_be;
	logic [1:0] lat;
	logic [63:0] got, ex;
	logic [63:0] acc_q[$], rd_q[$], rl_q[$];
	size_type seq[7] = '{SZ32, SZ16, SZ16, SZ8, SZ16, SZ16, SZ16};
	int failures, comparisons, cyc = 0;

	debug_mem_aligner u_debug_mem_aligner (.core_clk(core_clk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_size(cmd_size), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.rd_data(rd_data), .done(done), .realigned(realigned));
	mem_partner u_mem_partner (.core_clk(core_clk), .rst(rst),
		.mem_req(mem_req), .mem_addr(mem_addr), .lat(lat),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));

	function automatic logic [31:0] lmask(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		comparisons++;
		if (seen !== want) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, seen, want);
		end
	endtask

	task automatic conclude;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Note expectations, then hand the command over
	task automatic send(input op_type op, input size_type sz,
		input logic [23:0] ad, input logic [31:0] wd);
		logic [23:0] a, w;
		logic [1:0] l;
		logic [3:0] be;
		logic [7:0] b;
		logic [31:0] x;
		logic we;
		int i;
		we = op == OP_WRITE || op == OP_FILL;
		a = (op == OP_READ || op == OP_WRITE) ? ad : base + (24'h1 << psz);
		l = (sz == SZ32) ? 2'h0 : (sz == SZ16 && a[1:0] == 2'h3) ? 2'h2 : a[1:0];
		be = sz == SZ32 ? 4'hf : sz == SZ16 ? 4'hc >> l : 4'h8 >> l;
		w = {a[23:2], 2'h0};
		b = w[7:0] + 8'(l);
		x = sz == SZ32 ? wd : sz == SZ16 ? {16'h0, wd[15:0]} << (8 * (2 - l))
			: {24'h0, wd[7:0]} << (8 * (3 - l));
		acc_q.push_back({3'h0, we, w, be, x & lmask(be) & {32{we}}});
		if (!we)
			rd_q.push_back(sz == SZ32 ? {32'h0, b, b + 8'h1, b + 8'h2, b + 8'h3}
				: sz == SZ16 ? {48'h0, b, b + 8'h1} : {56'h0, b});
		rl_q.push_back({63'h0, (sz == SZ32 && a[1:0] != 2'h0)
			|| (sz == SZ16 && a[1:0] == 2'h3)});
		base = sz == SZ32 ? w : a;
		psz = sz;
		i = 0;
		while (cmd_ready !== 1'b1 && i < 100) begin
			@(posedge core_clk);
			#1 i++;
		end
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_size = sz;
		cmd_addr = ad;
		cmd_wdata = wd;
		@(posedge core_clk);
		#1 cmd_valid = 1'b0;
	endtask

	task automatic finish;
		int i;
		i = 0;
		while (done !== 1'b1 && i < 300) begin
			@(posedge core_clk);
			#1 i++;
		end
		if (i == 300)
			check(64'h0, 64'h1);
	endtask

	task automatic issue(input op_type op, input size_type sz,
		input logic [23:0] ad, input logic [31:0] wd);
		send(op, sz, ad, wd);
		finish();
	endtask

	task automatic drain;
		int i;
		i = 0;
		while (rd_q.size() != 0 && i < 500) begin
			@(posedge core_clk);
			#1 i++;
		end
		check(64'(rd_q.size()), 64'h0);
		check({63'h0, rd_valid}, 64'h0);
	endtask

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Host stalls on the read stream, memory latency varies
	always @(posedge core_clk) begin
		#1;
		rd_ready = !hold && ($urandom_range(3) != 0);
		lat = 2'($urandom_range(3));
	end

	// Compare each result seen with the oldest note
	always @(posedge core_clk) begin
		if (!rst && mem_req && mem_ack) begin
			got = {3'h0, mem_we, mem_addr, mem_be,
				mem_wdata & lmask(mem_be) & {32{mem_we}}};
			ex = acc_q.size() ? acc_q.pop_front() : ~got;
			check(got, ex);
		end
		if (!rst && rd_valid && rd_ready) begin
			ex = rd_q.size() ? rd_q.pop_front() : ~{32'h0, rd_data};
			check({32'h0, rd_data}, ex);
		end
		if (!rst && done) begin
			ex = rl_q.size() ? rl_q.pop_front() : 64'h2;
			check({63'h0, realigned}, ex);
		end
	end

	// Cut a hang short
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 8000) begin
			failures++;
			conclude();
		end
	end

	// Main sequence
	initial begin
		void'($urandom(32'he2f8c783));
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = OP_READ;
		cmd_size = SZ8;
		cmd_addr = 24'h0;
		cmd_wdata = 32'h0;
		rd_ready = 1'b0;
		lat = 2'h0;
		hold = 1'b0;
		base = 24'h0;
		psz = SZ8;
		failures = 0;
		comparisons = 0;
		repeat (2) @(posedge core_clk);
		#1 check({cmd_ready, mem_req, rd_valid, done, realigned},
			64'h10);
		rst = 1'b0;
		issue(OP_READ, SZ32, 24'h004003, 32'h0);
		foreach (seq[k])
			issue(OP_DUMP, seq[k], 24'h0, 32'h0);
		for (int s = 0; s < 3; s++) begin
			for (int o = 0; o < 4; o++) begin
				issue(OP_WRITE, size_type'(s), 24'h00a5f0 | 24'(o), $urandom);
				issue(OP_FILL, size_type'(s), 24'h0, $urandom);
				issue(OP_READ, size_type'(s), 24'h00a5f0 | 24'(o), 32'h0);
				issue(OP_DUMP, size_type'(s), 24'h0, 32'h0);
			end
		end
		repeat (40)
			issue(op_type'($urandom_range(3)), size_type'($urandom_range(2)),
				24'($urandom), $urandom);
		drain();
		hold = 1'b1;
		@(posedge core_clk);
		#1;
		repeat (17)
			issue(OP_DUMP, SZ8, 24'h0, 32'h0);
		send(OP_DUMP, SZ8, 24'h0, 32'h0);
		repeat (20) begin
			check({62'h0, cmd_ready, done}, 64'h0);
			@(posedge core_clk);
			#1;
		end
		hold = 1'b0;
		finish();
		drain();
		rst = 1'b1;
		base = 24'h0;
		psz = SZ8;
		repeat (2) @(posedge core_clk);
		#1 check({cmd_ready, mem_req, rd_valid, done, realigned},
			64'h10);
		rst = 1'b0;
		issue(OP_DUMP, SZ8, 24'h0, 32'h0);
		drain();
		conclude();
	end
endmodule
`default_nettype wire
